// file: logic/fast_read_engine.sv
// The implementer's own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module fast_read_engine
    import fast_read_pkg::*;
#(
    parameter int QOUT_DUMMY = DUMMY_QUAD_OUT
)
(
    // clock and reset
    input  wire logic     clk_sys,
    input  wire logic     rst,
    // register bus
    input  wire axi_m2s_t axi_i,
    output axi_s2m_t      axi_o,
    // serial link pins
    input  wire logic     sclk,
    input  wire logic     cs_n,
    input  wire logic [3:0] io_i,
    output logic [3:0]    io_o,
    output logic [3:0]    io_oe,
    // flash array read port
    output logic [23:0]   mem_addr,
    input  wire logic [7:0] mem_rdata
);

    if (QOUT_DUMMY < 1 || QOUT_DUMMY > 15)
    begin : g_chk
        $error("QOUT_DUMMY must lie in 1..15");
    end

    // ********************************
    // pin synchronisers and edges
    // ********************************
    logic [5:0] pin_m_q;
    logic [5:0] pin_s_q;
    logic       sclk_p_q;
    logic       cs_p_q;
    logic       cs_s;
    logic       sclk_s;
    logic [3:0] io_s;
    logic       sclk_rise;
    logic       sclk_fall;
    logic       cs_fall;
    logic       cs_rise;

    // all pins pass two flops; edges compare the second stage with a third flop
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            pin_m_q  <= 6'h20;
            pin_s_q  <= 6'h20;
            sclk_p_q <= 1'b0;
            cs_p_q   <= 1'b1;
        end
        else
        begin
            pin_m_q  <= {cs_n, sclk, io_i};
            pin_s_q  <= pin_m_q;
            sclk_p_q <= pin_s_q[4];
            cs_p_q   <= pin_s_q[5];
        end
    end

    assign cs_s      = pin_s_q[5];
    assign sclk_s    = pin_s_q[4];
    assign io_s      = pin_s_q[3:0];
    assign sclk_rise = sclk_s & ~sclk_p_q & ~cs_s;
    assign sclk_fall = ~sclk_s & sclk_p_q & ~cs_s;
    assign cs_fall   = ~cs_s & cs_p_q;
    assign cs_rise   = cs_s & ~cs_p_q;

    // ********************************
    // register bus slave
    // ********************************
    logic        awready_q;
    logic        wready_q;
    logic        bvalid_q;
    logic [1:0]  bresp_q;
    logic        arready_q;
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;
    logic        aw_have_q;
    logic        w_have_q;
    logic [11:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    logic        wr_go;
    logic [31:0] rd_mux;
    logic        rd_hit;

    logic        qe_q;
    logic        qpi_q;
    logic [2:0]  wrap_q;
    logic [1:0]  dsel_q;
    logic        mclr_q;
    state_t      state_q;
    cmd_t        cmd_q;
    logic [7:0]  mode_q;
    logic [23:0] mem_addr_q;
    logic        skip_q;

    assign wr_go = aw_have_q & w_have_q & ~bvalid_q;

    // write channel: address and data taken in either order
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            awaddr_q  <= 12'h000;
            wdata_q   <= 32'h0000_0000;
            wstrb_q   <= 4'h0;
        end
        else
        begin
            if (axi_i.awvalid && awready_q)
            begin
                aw_have_q <= 1'b1;
                awaddr_q  <= axi_i.awaddr;
                awready_q <= 1'b0;
            end
            if (axi_i.wvalid && wready_q)
            begin
                w_have_q <= 1'b1;
                wdata_q  <= axi_i.wdata;
                wstrb_q  <= axi_i.wstrb;
                wready_q <= 1'b0;
            end
            if (wr_go)
            begin
                bvalid_q  <= 1'b1;
                bresp_q   <= (awaddr_q == REG_CTRL) ? RESP_OKAY : RESP_SLVERR;
                aw_have_q <= 1'b0;
                w_have_q  <= 1'b0;
            end
            if (bvalid_q && axi_i.bready)
            begin
                bvalid_q  <= 1'b0;
                awready_q <= 1'b1;
                wready_q  <= 1'b1;
            end
        end
    end

    // control fields, per byte lane; mode clear is a one-cycle pulse
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            qe_q   <= 1'b0;
            qpi_q  <= 1'b0;
            wrap_q <= WRAP_RESET;
            dsel_q <= DSEL_RESET;
            mclr_q <= 1'b0;
        end
        else
        begin
            mclr_q <= 1'b0;
            if (wr_go && awaddr_q == REG_CTRL)
            begin
                if (wstrb_q[0])
                begin
                    qe_q   <= wdata_q[CTRL_QE];
                    qpi_q  <= wdata_q[CTRL_QPI];
                    wrap_q <= wdata_q[CTRL_WRAP_LO +: 3];
                end
                if (wstrb_q[1])
                begin
                    dsel_q <= wdata_q[CTRL_DSEL_LO +: 2];
                end
                if (wstrb_q[2])
                begin
                    mclr_q <= wdata_q[CTRL_MCLR];
                end
            end
        end
    end

    // read data selection; unmapped offsets read zero with an error
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b1;
        case (axi_i.araddr)
            REG_CTRL:
            begin
                rd_mux[CTRL_QE]           = qe_q;
                rd_mux[CTRL_QPI]          = qpi_q;
                rd_mux[CTRL_WRAP_LO +: 3] = wrap_q;
                rd_mux[CTRL_DSEL_LO +: 2] = dsel_q;
            end
            REG_STATUS: rd_mux = {19'h0, ~cs_s, state_q, skip_q, mode_q};
            REG_ADDR:   rd_mux = {8'h00, mem_addr_q};
            default:    rd_hit = 1'b0;
        endcase
    end

    // read channel: one read in flight
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h0000_0000;
            rresp_q   <= RESP_OKAY;
        end
        else if (axi_i.arvalid && arready_q)
        begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rdata_q   <= rd_mux;
            rresp_q   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (rvalid_q && axi_i.rready)
        begin
            rvalid_q  <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    assign axi_o = '{awready: awready_q, wready: wready_q,
                     bvalid: bvalid_q, bresp: bresp_q,
                     arready: arready_q, rvalid: rvalid_q,
                     rdata: rdata_q, rresp: rresp_q};

    // ********************************
    // serial read engine
    // ********************************
    logic [23:0] shin_q;
    logic [4:0]  bcnt_q;
    logic [3:0]  dmy_q;
    logic [7:0]  osh_q;
    logic [2:0]  obit_q;
    logic [3:0]  io_o_q;
    logic [3:0]  io_oe_q;
    logic [4:0]  win;
    logic [4:0]  nb;
    logic [23:0] sh_nx;
    logic [7:0]  word;
    logic        ow4;
    logic [2:0]  nobit;
    logic        byte_end;
    logic        wrap_on;
    logic [5:0]  wmask;
    logic [23:0] a_inc;
    logic [23:0] a_nx;
    logic [3:0]  mode_dmy;

    assign skip_q = (mode_q[5:4] == 2'b10);

    // lanes per clock for the phase in progress
    always_comb
    begin
        if (qpi_q || (state_q != ST_CMD && (cmd_q == CMD_QIO || cmd_q == CMD_WORD)))
            win = 5'd4;
        else if (state_q != ST_CMD && cmd_q == CMD_DUAL)
            win = 5'd2;
        else
            win = 5'd1;
    end

    always_comb
    begin
        case (win)
            5'd1:    sh_nx = {shin_q[22:0], io_s[0]};
            5'd2:    sh_nx = {shin_q[21:0], io_s[1:0]};
            default: sh_nx = {shin_q[19:0], io_s};
        endcase
    end

    assign nb = bcnt_q + win;

    // dummy clocks left after the mode byte
    always_comb
    begin
        if (qpi_q)
            mode_dmy = {1'b0, dsel_q, 1'b0};
        else if (cmd_q == CMD_QIO)
            mode_dmy = DUMMY_QUAD_IO;
        else if (cmd_q == CMD_WORD)
            mode_dmy = DUMMY_WORD_IO;
        else
            mode_dmy = 4'd0;
    end

    // outgoing byte and wrap-aware next address
    assign ow4      = (cmd_q != CMD_DUAL);
    assign word     = (obit_q == 3'd0) ? mem_rdata : osh_q;
    assign nobit    = obit_q + (ow4 ? 3'd4 : 3'd2);
    assign byte_end = (nobit == 3'd0);
    assign a_inc    = mem_addr_q + 24'h000001;
    assign wrap_on  = ~wrap_q[0] & ~qpi_q & (cmd_q == CMD_QIO || cmd_q == CMD_WORD);

    always_comb
    begin
        case (wrap_q[2:1])
            2'b00:   wmask = 6'h07;
            2'b01:   wmask = 6'h0f;
            2'b10:   wmask = 6'h1f;
            default: wmask = 6'h3f;
        endcase
    end

    assign a_nx = wrap_on ? {mem_addr_q[23:6], (mem_addr_q[5:0] & ~wmask) | (a_inc[5:0] & wmask)} : a_inc;

    // command sequencer; select high always wins over link edges
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            state_q    <= ST_IDLE;
            cmd_q      <= CMD_QOUT;
            mode_q     <= 8'h00;
            shin_q     <= 24'h000000;
            bcnt_q     <= 5'd0;
            dmy_q      <= 4'd0;
            mem_addr_q <= 24'h000000;
            osh_q      <= 8'h00;
            obit_q     <= 3'd0;
            io_o_q     <= 4'h0;
            io_oe_q    <= 4'h0;
        end
        else
        begin
            if (mclr_q)
                mode_q <= 8'h00;
            if (cs_s)
            begin
                state_q <= ST_IDLE;
                io_oe_q <= 4'h0;
            end
            else if (cs_fall)
            begin
                bcnt_q <= 5'd0;
                obit_q <= 3'd0;
                if (skip_q && (qe_q || cmd_q == CMD_DUAL))
                    state_q <= ST_ADDR;
                else
                    state_q <= ST_CMD;  // full opcode expected
            end
            else if (sclk_rise)
            begin
                unique case (state_q)
                    ST_CMD:
                    begin
                        shin_q <= sh_nx;
                        bcnt_q <= nb;
                        if (nb == OPC_BITS)
                        begin
                            bcnt_q  <= 5'd0;
                            state_q <= ST_IGNORE;
                            // disabled quad opcodes fall to ignore
                            if (sh_nx[7:0] == OP_MODE_RST)
                                mode_q <= 8'h00;  // mode reset opcode
                            else if (sh_nx[7:0] == OP_QUAD_OUT && qe_q && !qpi_q)
                            begin
                                cmd_q   <= CMD_QOUT;
                                state_q <= ST_ADDR;
                            end
                            else if (sh_nx[7:0] == OP_DUAL_IO && !qpi_q)
                            begin
                                cmd_q   <= CMD_DUAL;
                                state_q <= ST_ADDR;
                            end
                            else if (sh_nx[7:0] == OP_QUAD_IO && qe_q)
                            begin
                                cmd_q   <= CMD_QIO;
                                state_q <= ST_ADDR;
                            end
                            else if (sh_nx[7:0] == OP_WORD_IO && qe_q && !qpi_q)
                            begin
                                cmd_q   <= CMD_WORD;
                                state_q <= ST_ADDR;
                            end
                        end
                    end
                    ST_ADDR:
                    begin
                        shin_q <= sh_nx;
                        bcnt_q <= nb;
                        if (nb == ADDR_BITS)
                        begin
                            bcnt_q     <= 5'd0;
                            mem_addr_q <= sh_nx;
                            if (cmd_q == CMD_WORD)
                                mem_addr_q[0] <= 1'b0;
                            if (cmd_q == CMD_QOUT)
                            begin
                                dmy_q   <= 4'(QOUT_DUMMY);
                                state_q <= ST_DUMMY;
                            end
                            else
                                state_q <= ST_MODE;
                        end
                    end
                    ST_MODE:
                    begin
                        shin_q <= sh_nx;
                        bcnt_q <= nb;
                        if (nb == MODE_BITS)
                        begin
                            // whole byte kept, bits 5:4 used
                            bcnt_q <= 5'd0;
                            mode_q <= sh_nx[7:0];
                            dmy_q  <= mode_dmy;
                            state_q <= (mode_dmy == 4'd0) ? ST_DATA : ST_DUMMY;
                        end
                    end
                    ST_DUMMY:
                    begin
                        dmy_q <= dmy_q - 4'd1;
                        if (dmy_q == 4'd1)
                            state_q <= ST_DATA;
                    end
                    ST_IDLE, ST_DATA, ST_IGNORE:
                    begin
                        bcnt_q <= bcnt_q;
                    end
                    default:
                    begin
                        state_q <= ST_IGNORE;
                    end
                endcase
            end
            else if (sclk_fall && state_q == ST_DATA)
            begin
                // nibble per fall on four lanes, or two bits per fall on two lanes for dual
                io_o_q  <= ow4 ? word[7:4] : {2'b00, word[7:6]};
                io_oe_q <= ow4 ? 4'hf : 4'h3;
                osh_q   <= ow4 ? {word[3:0], 4'h0} : {word[5:0], 2'b00};
                obit_q  <= nobit;
                if (byte_end)
                    mem_addr_q <= a_nx;
            end
        end
    end

    assign io_o     = io_o_q;
    assign io_oe    = io_oe_q;
    assign mem_addr = mem_addr_q;

    // ********************************
    // assertions
    // ********************************
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    sequence sel_start;
        cs_fall && !cs_s;
    endsequence

    sequence data_fall;
        sclk_fall && state_q == ST_DATA;
    endsequence

    release_on_deselect_a: assert property (cs_rise |=> (io_oe_q == 4'h0 && state_q == ST_IDLE))
        else $error("lines still driven after select rose");
    ignore_undriven_a: assert property (state_q == ST_IGNORE |-> io_oe_q == 4'h0)
        else $error("ignored command drives the lines");
    quad_lanes_a: assert property (data_fall ##0 cmd_q != CMD_DUAL |=> io_oe_q == 4'hf)
        else $error("quad data not on four lines");
    dual_lanes_a: assert property (data_fall ##0 cmd_q == CMD_DUAL |=> io_oe_q == 4'h3)
        else $error("dual data not on two lines");
    quad_gate_a: assert property ($rose(state_q == ST_ADDR) && cmd_q != CMD_DUAL |-> $past(qe_q))
        else $error("quad read accepted without quad enable");
    skip_opcode_a: assert property (sel_start ##0 (skip_q && qe_q) |=> state_q == ST_ADDR)
        else $error("opcode not skipped");
    full_opcode_a: assert property (sel_start ##0 !skip_q |=> state_q == ST_CMD)
        else $error("opcode phase missing");
    mode_clear_a: assert property (mclr_q && state_q != ST_MODE |=> mode_q == 8'h00)
        else $error("mode byte not cleared");
    wrap_section_a: assert property (data_fall ##0 (byte_end && wrap_on) |=>
        (mem_addr_q & ~24'($past(wmask))) == ($past(mem_addr_q) & ~24'($past(wmask))))
        else $error("wrap left its section");
    word_dummy_a: assert property ($rose(state_q == ST_DUMMY) && cmd_q == CMD_WORD |-> dmy_q == 4'd2)
        else $error("word read dummy count wrong");

endmodule

`default_nettype wire

// file: logic/fast_read_pkg.sv
`default_nettype none

package fast_read_pkg;

    // opcodes served by the read engine
    localparam logic [7:0] OP_QUAD_OUT = 8'h6b;
    localparam logic [7:0] OP_DUAL_IO  = 8'hbb;
    localparam logic [7:0] OP_QUAD_IO  = 8'heb;
    localparam logic [7:0] OP_WORD_IO  = 8'he7;
    localparam logic [7:0] OP_MODE_RST = 8'hff;

    // phase lengths in bits and dummy clocks
    localparam logic [4:0] OPC_BITS       = 5'd8;
    localparam logic [4:0] ADDR_BITS      = 5'd24;
    localparam logic [4:0] MODE_BITS      = 5'd8;
    localparam int         DUMMY_QUAD_OUT = 8;
    localparam logic [3:0] DUMMY_QUAD_IO  = 4'd4;
    localparam logic [3:0] DUMMY_WORD_IO  = 4'd2;

    // register map, byte addresses
    localparam logic [11:0] REG_CTRL   = 12'h000;
    localparam logic [11:0] REG_STATUS = 12'h004;
    localparam logic [11:0] REG_ADDR   = 12'h008;

    // control field positions and reset values
    localparam int         CTRL_QE      = 0;
    localparam int         CTRL_QPI     = 1;
    localparam int         CTRL_WRAP_LO = 4;
    localparam int         CTRL_DSEL_LO = 8;
    localparam int         CTRL_MCLR    = 16;
    localparam logic [2:0] WRAP_RESET   = 3'b001;
    localparam logic [1:0] DSEL_RESET   = 2'b00;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_CMD    = 3'b001,
        ST_ADDR   = 3'b010,
        ST_MODE   = 3'b011,
        ST_DUMMY  = 3'b100,
        ST_DATA   = 3'b101,
        ST_IGNORE = 3'b110
    } state_t;

    typedef enum logic [1:0] {
        CMD_QOUT = 2'b00,
        CMD_DUAL = 2'b01,
        CMD_QIO  = 2'b10,
        CMD_WORD = 2'b11
    } cmd_t;

    typedef struct packed {
        logic        awvalid;
        logic [11:0] awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [11:0] araddr;
        logic        rready;
    } axi_m2s_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } axi_s2m_t;

endpackage

`default_nettype wire

// file: tb/flash_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// host controller stand-in: owns select, serial clock and host side of the lines
module flash_host_model (
    // clock
    input  wire logic       clk_sys,
    // link pins
    output logic            sclk,
    output logic            cs_n,
    output logic [3:0]      io_i,
    input  wire logic [3:0] io_o,
    input  wire logic [3:0] io_oe
);
    logic [3:0] drv_q;
    logic [3:0] hoe_q;
    logic [3:0] flip_q;
    logic [3:0] oe_or;

    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b1;
        drv_q = 4'h0;
        hoe_q = 4'h0;
        flip_q = 4'h5;
        oe_or = 4'h0;
    end

    // undriven lines toggle so a stale level never passes for data
    always @(posedge clk_sys) flip_q <= ~flip_q;

    // wire level: device drive first, then host drive
    always_comb
        for (int k = 0; k < 4; k++)
            io_i[k] = io_oe[k] ? io_o[k] : (hoe_q[k] ? drv_q[k] : flip_q[k]);

    task automatic tick(input logic [3:0] dv, input logic [3:0] oe, output logic [3:0] q);
        drv_q <= dv;
        hoe_q <= oe;
        sclk <= 1'b0;
        repeat (4) @(posedge clk_sys);
        sclk <= 1'b1;
        repeat (4) @(posedge clk_sys);
        q = io_i;
        oe_or = oe_or | io_oe;
    endtask

    task automatic send(input logic [23:0] v, input int n, input int w, input int dr);
        logic [3:0] q;
        for (int i = 0; i < n / w; i++)
            tick(4'((v >> (n - w * (i + 1))) & ((1 << w) - 1)), (i < dr) ? 4'((1 << w) - 1) : 4'h0, q);
    endtask

    task automatic rd(input int n, input int w, output logic [7:0] b[$]);
        logic [3:0] q;
        logic [7:0] s;
        b = {};
        for (int i = 0; i < n; i++)
        begin
            for (int j = 0; j < 8 / w; j++)
            begin
                tick(4'h0, 4'h0, q);
                s = (s << w) | 8'(q & 4'((1 << w) - 1));
            end
            b.push_back(s);
        end
    endtask

    // deselect idles the clock low and lets go of the lines
    task automatic sel(input logic on);
        cs_n <= ~on;
        sclk <= 1'b0;
        hoe_q <= 4'h0;
        if (on)
            oe_or = 4'h0;
        repeat (6) @(posedge clk_sys);
    endtask
endmodule

`default_nettype wire

// file: tb/multi_io_fast_read_engine_tb.sv
`timescale 1ns/1ps
`default_nettype none

module multi_io_fast_read_engine_tb
    import fast_read_pkg::*;
;
    localparam int QD = 3;   // short quad-output dummy run
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    axi_m2s_t    axi_m = '0;
    axi_s2m_t    axi_s;
    logic        sclk;
    logic        cs_n;
    logic [3:0]  io_i;
    logic [3:0]  io_o;
    logic [3:0]  io_oe;
    logic [23:0] mem_addr;
    logic [7:0]  mem_rdata;
    logic [31:0] d;
    logic [1:0]  r;
    logic [15:0] seed = 16'd17465;
    logic [7:0]  q[$];
    logic [7:0]  qops[3] = '{OP_QUAD_OUT, OP_QUAD_IO, OP_WORD_IO};
    int          a;
    int          error_cnt = 0;
    int          num_checks = 0;

    initial
    begin
        forever #12.5 clk_sys = ~clk_sys;
    end

    // array stand-in: byte mixes the two low address bytes
    assign mem_rdata = mem_addr[7:0] ^ mem_addr[15:8] ^ 8'h3c;

    fast_read_engine #(.QOUT_DUMMY(QD)) fast_read_engine_i (.clk_sys(clk_sys), .rst(rst), .axi_i(axi_m),
        .axi_o(axi_s), .sclk(sclk), .cs_n(cs_n), .io_i(io_i), .io_o(io_o), .io_oe(io_oe),
        .mem_addr(mem_addr), .mem_rdata(mem_rdata));

    flash_host_model host_i (.clk_sys(clk_sys), .sclk(sclk), .cs_n(cs_n), .io_i(io_i), .io_o(io_o),
        .io_oe(io_oe));

    // ****************
    // helpers
    // ****************
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // reference byte stream, wrapping inside an aligned section when len is set
    function automatic void expect_run(input int x, input int n, input int len, output logic [7:0] e[$]);
        e = {};
        for (int i = 0; i < n; i++)
        begin
            e.push_back(8'(x ^ (x >> 8) ^ 8'h3c));
            x = (len > 0) ? ((x & ~(len - 1)) | ((x + 1) & (len - 1))) : x + 1;
        end
    endfunction

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic complete_run();
        if (error_cnt == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // write: aw and w offered together, each dropped once taken; response kept in r
    task automatic axw(input logic [11:0] ad, input logic [31:0] dv, input logic [3:0] sb);
        axi_m.awvalid <= 1'b1;
        axi_m.awaddr <= ad;
        axi_m.wvalid <= 1'b1;
        axi_m.wdata <= dv;
        axi_m.wstrb <= sb;
        axi_m.bready <= 1'b1;
        do
        begin
            @(posedge clk_sys);
            if (axi_s.awready)
                axi_m.awvalid <= 1'b0;
            if (axi_s.wready)
                axi_m.wvalid <= 1'b0;
        end while (!axi_s.bvalid);
        r = axi_s.bresp;
        axi_m.bready <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic axr(input logic [11:0] ad);
        axi_m.arvalid <= 1'b1;
        axi_m.araddr <= ad;
        axi_m.rready <= 1'b1;
        do
        begin
            @(posedge clk_sys);
            if (axi_s.arready)
                axi_m.arvalid <= 1'b0;
        end while (!axi_s.rvalid);
        d = axi_s.rdata;
        r = axi_s.rresp;
        axi_m.rready <= 1'b0;
        @(posedge clk_sys);
    endtask

    // frame head: opcode (ow lanes, 0 skips it), address, optional mode, dummies
    task automatic hdr(input int ow, input logic [7:0] op, input int ad, input int aw, input bit md,
                       input logic [7:0] m, input int nd);
        host_i.sel(1'b1);
        if (ow > 0)
            host_i.send(24'(op), 8, ow, 8);
        host_i.send(24'(ad), 24, aw, 24);
        if (md)
            host_i.send(24'(m), 8, aw, 4 / aw);
        host_i.send(24'h0, nd, 1, 0);
    endtask

    task automatic rdc(input string nm, input int n, input int w, input int ad, input int len);
        logic [7:0] e[$];
        host_i.rd(n, w, q);
        expect_run(ad, n, len, e);
        host_i.sel(1'b0);
        for (int i = 0; i < n; i++)
            chk(nm, 32'(e[i]), 32'(q[i]));
        chk("line release", 32'h0, 32'(io_oe));
    endtask

    // ****************
    // scenarios
    // ****************
    initial
    begin
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        axr(REG_CTRL);
        chk("ctrl reset", 32'h10, d);
        axr(12'h00c);
        chk("unmapped resp", 32'(RESP_SLVERR), 32'(r));
        foreach (qops[i])
        begin
            hdr(1, qops[i], 0, 1, 0, 8'h0, 8);
            host_i.rd(1, 4, q);
            host_i.sel(1'b0);
            chk("refused drive", 32'h0, 32'(host_i.oe_or));
        end
        axw(REG_CTRL, 32'h11, 4'hf);
        chk("write resp", 32'(RESP_OKAY), 32'(r));
        seed = lfsr_next(seed);
        axw(REG_STATUS, 32'(seed), 4'hf);
        chk("refused write", 32'(RESP_SLVERR), 32'(r));
        a = int'(seed);
        hdr(1, OP_QUAD_OUT, a, 1, 0, 8'h0, QD);
        rdc("quad out", 3, 4, a, 0);
        axr(REG_ADDR);
        chk("addr reg", 32'(a + 3), d);
        seed = lfsr_next(seed);
        hdr(1, OP_DUAL_IO, int'(seed), 2, 1, 8'h2a, 0);
        rdc("dual", 2, 2, int'(seed), 0);
        hdr(0, 8'h0, 24'h000420, 2, 1, 8'hf0, 0);
        rdc("dual skip", 2, 2, 24'h000420, 0);
        hdr(1, OP_DUAL_IO, 24'h000530, 2, 1, 8'h20, 0);
        rdc("dual reopen", 2, 2, 24'h000530, 0);
        host_i.sel(1'b1);
        host_i.send(24'hffff, 16, 1, 16);
        host_i.sel(1'b0);
        axr(REG_STATUS);
        chk("dual disarmed", 32'h0, 32'(d[8]));
        for (int c = 0; c < 4; c++)
        begin
            axw(REG_CTRL, 32'h1 | 32'(c << 5), 4'hf);
            a = 24'h000100 + (8 << c) - 2;
            hdr(1, OP_QUAD_IO, a, 4, 1, 8'h50, DUMMY_QUAD_IO);
            rdc("wrap burst", 4, 4, a, 8 << c);
        end
        axr(REG_STATUS);
        chk("mode byte", 32'h5, 32'(d[7:4]));
        // only the clear lane is written: other fields must stay
        axw(REG_CTRL, 32'h0001_0000, 4'h4);
        axr(REG_STATUS);
        chk("soft clear", 32'h0, 32'(d[7:0]));
        axr(REG_CTRL);
        chk("lane kept", 32'h61, d);
        axw(REG_CTRL, 32'h11, 4'hf);
        hdr(1, OP_WORD_IO, 24'h000202, 4, 1, 8'h20, DUMMY_WORD_IO);
        rdc("word", 2, 4, 24'h000202, 0);
        hdr(0, 8'h0, 24'h000310, 4, 1, 8'h20, DUMMY_WORD_IO);
        rdc("word skip", 2, 4, 24'h000310, 0);
        host_i.sel(1'b1);
        host_i.send(24'hff, 8, 1, 8);
        host_i.sel(1'b0);
        axr(REG_STATUS);
        chk("skip disarmed", 32'h0, 32'(d[8]));
        host_i.sel(1'b1);
        host_i.send(24'(OP_MODE_RST), 8, 1, 8);
        host_i.sel(1'b0);
        axr(REG_STATUS);
        chk("mode cleared", 32'h0, 32'(d[7:0]));
        for (int s = 0; s < 4; s++)
        begin
            axw(REG_CTRL, 32'h3 | 32'(s << 8), 4'hf);
            hdr(4, OP_QUAD_IO, 24'h000107, 4, 1, 8'h00, 2 * s);
            rdc("four wire", 2, 4, 24'h000107, 0);
        end
        complete_run();
    end

    // watchdog sized well above the expected run length
    initial
    begin
        repeat (90000) @(posedge clk_sys);
        error_cnt++;
        complete_run();
    end
endmodule

`default_nettype wire
